// ### verilog/icsb_pkg.sv
package icsb_pkg;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int HALF_BIT_NS = 5000;
	localparam int HALF_BIT_CYC = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] HALF_RELOAD = 8'(HALF_BIT_CYC - 1);

	// ==========================================================
	// Register map and alias kinds
	localparam logic [7:0] OFF_CON = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_ADD = 8'h20;
	localparam logic [7:0] OFF_TRN = 8'h50;
	localparam logic [7:0] OFF_RCV = 8'h60;
	localparam logic [1:0] ALIAS_WR = 2'h0;
	localparam logic [1:0] ALIAS_CLR = 2'h1;
	localparam logic [1:0] ALIAS_SET = 2'h2;
	localparam logic [1:0] ALIAS_INV = 2'h3;
	localparam logic [15:0] CON_RESET = 16'h1000;

	// ==========================================================
	// Bus constants
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [4:0] TEN_BIT_HDR = 5'h1E;
	localparam logic [3:0] RSV_LOW = 4'h0;
	localparam logic [3:0] RSV_HIGH = 4'hF;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;

	// ==========================================================
	// Types
	typedef struct packed {
		logic on;
		logic rsv14;
		logic halt_in_idle;
		logic clock_release;
		logic strict;
		logic ten_bit_addressing;
		logic slew_off;
		logic smbus_levels;
		logic general_call_enable;
		logic stretch_enable;
		logic ack_value_to_send;
		logic ack_sequence_request;
		logic master_receive_enable;
		logic stop_request;
		logic restart_request;
		logic start_request;
	} icsb_con_t;

	typedef struct packed {
		logic ack_missing_flag;
		logic master_tx_active;
		logic [2:0] rsv13;
		logic collision_flag;
		logic general_call_seen;
		logic ten_bit_match;
		logic tx_write_collision;
		logic rx_overflow;
		logic data_not_addr;
		logic stop_seen;
		logic start_seen;
		logic read_not_write;
		logic rx_holding_full;
		logic tx_holding_full;
	} icsb_stat_t;

	typedef enum logic [2:0] {
		M_IDLE = 3'h0,
		M_START = 3'h1,
		M_RESTART = 3'h2,
		M_STOP = 3'h3,
		M_TX = 3'h4,
		M_RX = 3'h5,
		M_ACK = 3'h6
	} icsb_mst_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_ADDR = 3'h1,
		S_ADDR2 = 3'h2,
		S_RX = 3'h3,
		S_TX = 3'h4,
		S_IGNORE = 3'h5
	} icsb_sst_t;

	typedef struct packed {
		icsb_con_t con;
		icsb_stat_t stat;
		logic [7:0] trn;
		logic [7:0] rcv;
		logic [7:0] shf;
		logic [9:0] own;
		logic [31:0] rdata;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_q;
		logic sda_q;
		logic on_q;
		icsb_mst_t mst;
		icsb_sst_t sst;
		logic [3:0] bitn;
		logic [3:0] sbit;
		logic phase;
		logic [7:0] tmr;
		logic mowned;
		logic m_first;
		logic m_scl;
		logic m_sda;
		logic s_scl;
		logic s_sda;
		logic s_ack;
		logic scl_oe;
		logic sda_oe;
		logic scl_o;
		logic sda_o;
	} icsb_st_t;

	localparam icsb_st_t ST_RESET = '{
		con: icsb_con_t'(CON_RESET),
		mst: M_IDLE,
		sst: S_IDLE,
		scl_s: 2'h3,
		sda_s: 2'h3,
		scl_q: 1'b1,
		sda_q: 1'b1,
		scl_o: 1'b1,
		sda_o: 1'b1,
		default: '0
	};
endpackage : icsb_pkg

// ### verilog/icsb_ctrl.sv
// Local design decisions: the register addresses and the strobed register port.
module icsb_ctrl (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic idle_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe_o,
	output logic sda_o,
	output logic sda_oe_o,
	output logic pins_en_o
);
	// ==========================================================
	// Helpers
	function automatic logic [15:0] alias_f(input logic [15:0] old, input logic [15:0] wd,
			input logic [1:0] kind);
		logic [15:0] r;
		case (kind)
			icsb_pkg::ALIAS_CLR: r = old & ~wd;
			icsb_pkg::ALIAS_SET: r = old | wd;
			icsb_pkg::ALIAS_INV: r = old ^ wd;
			default: r = wd;
		endcase
		return r;
	endfunction : alias_f

	function automatic logic rsv_f(input logic [6:0] a);
		return (a[6:3] == icsb_pkg::RSV_LOW) || (a[6:3] == icsb_pkg::RSV_HIGH);
	endfunction : rsv_f

	icsb_pkg::icsb_st_t st;
	icsb_pkg::icsb_st_t n;

	// ==========================================================
	// Next state
	always_comb begin
		logic scl_in;
		logic sda_in;
		logic rise;
		logic fall;
		logic sta;
		logic sto;
		logic hold;
		logic tick;
		logic coll;
		logic busy;
		logic [15:0] w;
		icsb_pkg::icsb_stat_t ws;
		scl_in = st.scl_s[1];
		sda_in = st.sda_s[1];
		rise = scl_in & ~st.scl_q;
		fall = ~scl_in & st.scl_q;
		sta = scl_in & st.scl_q & ~sda_in & st.sda_q;
		sto = scl_in & st.scl_q & sda_in & ~st.sda_q;
		hold = 1'b0;
		tick = 1'b0;
		coll = 1'b0;
		busy = (st.mst != icsb_pkg::M_IDLE) || st.stat.tx_holding_full;
		w = alias_f(16'h0000, wdata_i[15:0], addr_i[3:2]);
		ws = icsb_pkg::icsb_stat_t'(w);
		n = st;
		n.rdata = 32'h0000_0000;
		n.scl_s = {st.scl_s[0], scl_i};
		n.sda_s = {st.sda_s[0], sda_i};
		n.scl_q = scl_in;
		n.sda_q = sda_in;
		n.on_q = st.con.on;

		// ======================================================
		// Register port
		if (wr_i) begin
			if (addr_i[7:4] == icsb_pkg::OFF_CON[7:4]) begin
				w = alias_f(st.con, wdata_i[15:0], addr_i[3:2]);
				n.con = icsb_pkg::icsb_con_t'(w);
				n.con.rsv14 = 1'b0;
				if (!st.con.stretch_enable) begin
					n.con.clock_release = st.con.clock_release | n.con.clock_release;
				end
			end else if (addr_i[7:4] == icsb_pkg::OFF_STAT[7:4]) begin
				w = alias_f(st.stat, wdata_i[15:0], addr_i[3:2]);
				ws = icsb_pkg::icsb_stat_t'(w);
				n.stat.tx_write_collision = st.stat.tx_write_collision & ws.tx_write_collision;
				n.stat.rx_overflow = st.stat.rx_overflow & ws.rx_overflow;
			end else if (addr_i[7:4] == icsb_pkg::OFF_ADD[7:4]) begin
				w = alias_f({6'h00, st.own}, wdata_i[15:0], addr_i[3:2]);
				n.own = w[9:0];
			end else if (addr_i[7:4] == icsb_pkg::OFF_TRN[7:4]) begin
				w = alias_f({8'h00, st.trn}, wdata_i[15:0], addr_i[3:2]);
				if (busy) begin
					n.stat.tx_write_collision = 1'b1;
				end else begin
					n.trn = w[7:0];
					n.stat.tx_holding_full = 1'b1;
				end
			end
		end
		if (rd_i) begin
			if (addr_i[7:2] == icsb_pkg::OFF_CON[7:2]) begin
				n.rdata = {16'h0000, st.con};
			end else if (addr_i[7:2] == icsb_pkg::OFF_STAT[7:2]) begin
				n.rdata = {16'h0000, st.stat};
			end else if (addr_i[7:2] == icsb_pkg::OFF_ADD[7:2]) begin
				n.rdata = {22'h000000, st.own};
			end else if (addr_i[7:2] == icsb_pkg::OFF_TRN[7:2]) begin
				n.rdata = {24'h000000, st.trn};
			end else if (addr_i[7:2] == icsb_pkg::OFF_RCV[7:2]) begin
				n.rdata = {24'h000000, st.rcv};
				n.stat.rx_holding_full = 1'b0;
			end
		end

		// ======================================================
		// Bus condition status, seen by master and slave alike
		if (st.con.on && !st.on_q) begin
			n.stat.collision_flag = 1'b0;
		end
		if (sta) begin
			n.stat.start_seen = 1'b1;
			n.stat.stop_seen = 1'b0;
		end
		if (sto) begin
			n.stat.stop_seen = 1'b1;
			n.stat.start_seen = 1'b0;
			n.stat.general_call_seen = 1'b0;
			n.stat.ten_bit_match = 1'b0;
			n.sst = icsb_pkg::S_IDLE;
			n.s_ack = 1'b0;
		end

		if (!st.con.on) begin
			n.mst = icsb_pkg::M_IDLE;
			n.sst = icsb_pkg::S_IDLE;
			n.m_scl = 1'b0;
			n.m_sda = 1'b0;
			n.s_ack = 1'b0;
			n.mowned = 1'b0;
			n.stat.master_tx_active = 1'b0;
		end else if (!(st.con.halt_in_idle && idle_i)) begin
			// ==================================================
			// Master engine; a slave holding the clock low stalls the timer.
			hold = (st.mst != icsb_pkg::M_IDLE) && !st.m_scl && !scl_in;
			if (st.mst != icsb_pkg::M_IDLE) begin
				if (hold) begin
					n.tmr = icsb_pkg::HALF_RELOAD;
				end else if (st.tmr != 8'h00) begin
					n.tmr = st.tmr - 8'h01;
				end else begin
					tick = 1'b1;
					n.tmr = icsb_pkg::HALF_RELOAD;
				end
			end
			unique case (st.mst)
				icsb_pkg::M_IDLE: begin
					n.tmr = icsb_pkg::HALF_RELOAD;
					n.bitn = 4'h0;
					n.phase = 1'b0;
					if (st.con.start_request) begin
						if (!scl_in || !sda_in) begin
							coll = 1'b1;
						end else begin
							n.mst = icsb_pkg::M_START;
							n.m_sda = 1'b1;
						end
					end else if (st.con.restart_request) begin
						n.mst = icsb_pkg::M_RESTART;
						n.m_sda = 1'b0;
					end else if (st.con.stop_request) begin
						n.mst = icsb_pkg::M_STOP;
						n.m_sda = 1'b1;
					end else if (st.con.master_receive_enable) begin
						n.mst = icsb_pkg::M_RX;
						n.m_sda = 1'b0;
					end else if (st.con.ack_sequence_request) begin
						n.mst = icsb_pkg::M_ACK;
						n.m_sda = ~st.con.ack_value_to_send;
					end else if (st.stat.tx_holding_full && st.mowned) begin
						n.m_first = 1'b0;
						if (st.m_first && st.con.strict && rsv_f(st.trn[7:1])) begin
							n.stat.tx_holding_full = 1'b0;
							n.stat.ack_missing_flag = 1'b1;
						end else begin
							n.mst = icsb_pkg::M_TX;
							n.stat.master_tx_active = 1'b1;
							n.shf = st.trn;
							n.m_sda = ~st.trn[7];
						end
					end
				end
				icsb_pkg::M_START: begin
					if (tick) begin
						n.bitn = st.bitn + 4'h1;
						n.m_scl = 1'b1;
						if (st.bitn == 4'h1) begin
							n.con.start_request = 1'b0;
							n.mowned = 1'b1;
							n.m_first = 1'b1;
							n.mst = icsb_pkg::M_IDLE;
						end
					end
				end
				icsb_pkg::M_RESTART: begin
					if (tick) begin
						n.bitn = st.bitn + 4'h1;
						unique case (st.bitn)
							4'h0: n.m_scl = 1'b0;
							4'h1: n.m_sda = 1'b1;
							4'h2: n.m_scl = 1'b1;
							default: begin
								n.con.restart_request = 1'b0;
								n.m_first = 1'b1;
								n.mst = icsb_pkg::M_IDLE;
							end
						endcase
					end
				end
				icsb_pkg::M_STOP: begin
					if (tick) begin
						n.bitn = st.bitn + 4'h1;
						unique case (st.bitn)
							4'h0: n.m_scl = 1'b0;
							4'h1: n.m_sda = 1'b0;
							default: begin
								n.con.stop_request = 1'b0;
								n.mowned = 1'b0;
								n.mst = icsb_pkg::M_IDLE;
							end
						endcase
					end
				end
				icsb_pkg::M_TX, icsb_pkg::M_RX, icsb_pkg::M_ACK: begin
					if (tick && !st.phase) begin
						n.m_scl = 1'b0;
						n.phase = 1'b1;
					end else if (tick) begin
						n.m_scl = 1'b1;
						n.phase = 1'b0;
						n.bitn = st.bitn + 4'h1;
						if (st.mst == icsb_pkg::M_ACK) begin
							n.con.ack_sequence_request = 1'b0;
							n.m_sda = 1'b0;
							n.mst = icsb_pkg::M_IDLE;
						end else if (st.mst == icsb_pkg::M_RX) begin
							n.shf = {st.shf[6:0], sda_in};
							if (st.bitn == icsb_pkg::BIT_LAST) begin
								n.con.master_receive_enable = 1'b0;
								n.mst = icsb_pkg::M_IDLE;
								if (st.stat.rx_holding_full && n.stat.rx_holding_full) begin
									n.stat.rx_overflow = 1'b1;
								end else begin
									n.rcv = {st.shf[6:0], sda_in};
									n.stat.rx_holding_full = 1'b1;
								end
							end
						end else if (st.bitn != icsb_pkg::BIT_ACK) begin
							if (!st.m_sda && !sda_in) begin
								coll = 1'b1;
							end else begin
								n.shf = {st.shf[6:0], 1'b0};
								n.m_sda = (st.bitn == icsb_pkg::BIT_LAST) ? 1'b0 : ~st.shf[6];
							end
						end else begin
							n.stat.ack_missing_flag = sda_in;
							n.stat.master_tx_active = 1'b0;
							n.stat.tx_holding_full = 1'b0;
							n.mst = icsb_pkg::M_IDLE;
						end
					end
				end
				default: n.mst = icsb_pkg::M_IDLE;
			endcase
			if (coll) begin
				n.stat.collision_flag = 1'b1;
				n.stat.master_tx_active = 1'b0;
				n.mst = icsb_pkg::M_IDLE;
				n.m_scl = 1'b0;
				n.m_sda = 1'b0;
				n.mowned = 1'b0;
				n.con.start_request = 1'b0;
				n.con.restart_request = 1'b0;
				n.con.stop_request = 1'b0;
				n.con.master_receive_enable = 1'b0;
				n.con.ack_sequence_request = 1'b0;
			end

			// ==================================================
			// Slave engine, only while this end does not own the bus.
			if (st.mst == icsb_pkg::M_IDLE && !st.mowned) begin
				if (sta) begin
					n.sst = icsb_pkg::S_ADDR;
					n.sbit = 4'h0;
					n.s_ack = 1'b0;
				end else if (st.sst != icsb_pkg::S_IDLE && !sto) begin
					if (rise) begin
						if (st.sbit < icsb_pkg::BIT_ACK) begin
							n.shf = {st.shf[6:0], sda_in};
						end
						if (st.sst == icsb_pkg::S_TX && st.sbit == icsb_pkg::BIT_ACK && sda_in) begin
							n.sst = icsb_pkg::S_IGNORE;
						end
						n.sbit = st.sbit + 4'h1;
					end
					if (fall && st.sbit == icsb_pkg::BIT_ACK) begin
						unique case (st.sst)
							icsb_pkg::S_ADDR: begin
								n.sst = icsb_pkg::S_IGNORE;
								if (st.shf == icsb_pkg::GEN_CALL_ADDR && st.con.general_call_enable) begin
									n.stat.general_call_seen = 1'b1;
									n.stat.data_not_addr = 1'b0;
									n.stat.read_not_write = 1'b0;
									n.s_ack = 1'b1;
									n.sst = icsb_pkg::S_RX;
								end else if (!st.con.ten_bit_addressing && st.shf[7:1] == st.own[6:0]
										&& !(st.con.strict && rsv_f(st.shf[7:1]))) begin
									n.stat.data_not_addr = 1'b0;
									n.stat.read_not_write = st.shf[0];
									n.s_ack = 1'b1;
									n.sst = st.shf[0] ? icsb_pkg::S_TX : icsb_pkg::S_RX;
								end else if (st.con.ten_bit_addressing && st.shf[7:3] == icsb_pkg::TEN_BIT_HDR
										&& st.shf[2:1] == st.own[9:8]) begin
									n.stat.read_not_write = st.shf[0];
									if (!st.shf[0]) begin
										n.s_ack = 1'b1;
										n.sst = icsb_pkg::S_ADDR2;
									end else if (st.stat.ten_bit_match) begin
										n.stat.data_not_addr = 1'b0;
										n.s_ack = 1'b1;
										n.sst = icsb_pkg::S_TX;
									end
								end
							end
							icsb_pkg::S_ADDR2: begin
								n.sst = icsb_pkg::S_IGNORE;
								if (st.shf == st.own[7:0]) begin
									n.stat.ten_bit_match = 1'b1;
									n.stat.data_not_addr = 1'b0;
									n.s_ack = 1'b1;
									n.sst = icsb_pkg::S_RX;
								end
							end
							icsb_pkg::S_RX: begin
								n.stat.data_not_addr = 1'b1;
								if (st.stat.rx_holding_full && n.stat.rx_holding_full) begin
									n.stat.rx_overflow = 1'b1;
								end else begin
									n.rcv = st.shf;
									n.stat.rx_holding_full = 1'b1;
									n.s_ack = 1'b1;
								end
							end
							icsb_pkg::S_TX: begin
								n.stat.tx_holding_full = 1'b0;
								n.s_ack = 1'b0;
							end
							default: n.s_ack = 1'b0;
						endcase
					end
					if (fall && st.sbit == icsb_pkg::BIT_END) begin
						n.sbit = 4'h0;
						n.s_ack = 1'b0;
						if (st.sst == icsb_pkg::S_TX) begin
							n.con.clock_release = 1'b0;
						end
						if (st.sst == icsb_pkg::S_RX && st.stat.data_not_addr && st.con.stretch_enable) begin
							n.con.clock_release = 1'b0;
						end
					end
				end
			end
			// The data line only moves while the clock is low, so no false start or stop appears.
			if (!scl_in) begin
				n.s_sda = (n.sst == icsb_pkg::S_TX && n.sbit < icsb_pkg::BIT_ACK) ?
					~st.trn[3'(icsb_pkg::BIT_LAST - n.sbit)] : n.s_ack;
			end
			n.s_scl = (n.sst == icsb_pkg::S_TX || n.sst == icsb_pkg::S_RX) && !n.con.clock_release
				&& (st.s_scl || !scl_in);
		end
		if (!st.con.on || n.sst == icsb_pkg::S_IDLE || n.sst == icsb_pkg::S_IGNORE) begin
			n.s_sda = 1'b0;
			n.s_scl = 1'b0;
		end
		n.sda_oe = n.m_sda | n.s_sda;
		n.scl_oe = n.m_scl | n.s_scl;
		n.sda_o = ~n.sda_oe;
		n.scl_o = ~n.scl_oe;
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= icsb_pkg::ST_RESET;
		end else begin
			st <= n;
		end
	end

	assign rdata_o = st.rdata;
	assign scl_o = st.scl_o;
	assign scl_oe_o = st.scl_oe;
	assign sda_o = st.sda_o;
	assign sda_oe_o = st.sda_oe;
	assign pins_en_o = st.con.on;
endmodule : icsb_ctrl

// ### bench/icsb_ctrl_chk_sva.sv
module icsb_ctrl_chk (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic idle_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_o,
	input wire logic scl_oe_o,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic pins_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Shadow of the halt bit, since the checker cannot see the control register.
	logic halt;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			halt <= 1'b0;
		end else if (wr_i && addr_i[7:4] == 4'h0) begin
			case (addr_i[3:2])
				2'h0: halt <= wdata_i[13];
				2'h1: halt <= halt & ~wdata_i[13];
				2'h2: halt <= halt | wdata_i[13];
				default: halt <= halt ^ wdata_i[13];
			endcase
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// ==========================================================
	// Assertions
	chk_enable_set: assert property (
		wr_i && addr_i == 8'h08 && wdata_i[15] |=> pins_en_o)
		else $error("enable not set by set alias");
	chk_enable_clear: assert property (
		wr_i && addr_i == 8'h04 && wdata_i[15] |=> !pins_en_o)
		else $error("enable not cleared by clear alias");
	chk_enable_flip: assert property (
		wr_i && addr_i == 8'h0C && wdata_i[15] |=> pins_en_o != $past(pins_en_o))
		else $error("enable not inverted");
	chk_pins_idle: assert property (
		!pins_en_o && !$past(pins_en_o) |-> !scl_oe_o && !sda_oe_o)
		else $error("lines driven while disabled");
	chk_halt_freeze: assert property (
		halt && idle_i |=> $stable(scl_oe_o) && $stable(sda_oe_o))
		else $error("line drive moved while halted");
	chk_start_timing: assert property (
		$rose(sda_oe_o) && scl_i |=> !scl_oe_o[*8] ##[100:130] scl_oe_o)
		else $error("start condition timing wrong");
	chk_stop_timing: assert property (
		$fell(sda_oe_o) && scl_i && pins_en_o |-> !$past(scl_oe_o, 100))
		else $error("stop without clock high phase");
	chk_alias_read: assert property (
		rd_i && addr_i[3:2] != 2'h0 |=> rdata_o == 32'h0)
		else $error("alias read not zero");
endmodule : icsb_ctrl_chk

bind icsb_ctrl icsb_ctrl_chk i_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i),
	.scl_i(scl_i), .sda_i(sda_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .pins_en_o(pins_en_o));

// ### bench/icsb_slave_model.sv
module icsb_slave_model #(
	parameter logic [6:0] ADDR = 7'h2A,
	parameter logic [7:0] TXB = 8'hA5
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic slow_i,
	output logic scl_oe_o,
	output logic sda_oe_o,
	output logic [7:0] last_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	int n;
	logic act, first, hit, rnw;
	initial begin
		{scl_oe_o, sda_oe_o, act, first, hit, rnw} = '0;
		n = 0;
		sh = '0;
		last_o = '0;
	end
	// ==========================================================
	// Start and stop are seen as data moving while the clock is high.
	always @(negedge sda_i) if (scl_i) begin
		act = 1'b1;
		first = 1'b1;
		n = 0;
	end
	always @(posedge sda_i) if (scl_i) act = 1'b0;
	always @(posedge scl_i) if (act) begin
		if (n < 8) sh = {sh[6:0], sda_i};
		else if (rnw && hit && !first && sda_i) act = 1'b0;
		n++;
	end
	// Data only moves while the clock is low; a slow peer holds it low too.
	// The hold outlasts a half bit, so the master really has to wait for the line.
	always @(negedge scl_i) begin
		logic nx;
		nx = 1'b0;
		if (act && n == 8) begin
			if (first) begin
				hit = (sh[7:1] == ADDR);
				rnw = sh[0];
			end else if (!rnw) begin
				last_o = sh;
			end
			nx = hit && !(rnw && !first);
			first = 1'b0;
		end else if (act && n == 9) begin
			n = 0;
		end
		if (act && hit && rnw && !first && n < 8) nx = !TXB[7 - n];
		sda_oe_o = nx;
		if (slow_i) begin
			scl_oe_o = 1'b1;
			#8000;
			scl_oe_o = 1'b0;
		end
	end
endmodule : icsb_slave_model

// ### bench/i2c_control_status_bank_tb_top.sv
module i2c_control_status_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic idle_i = 1'b0;
	logic m_scl = 1'b0;
	logic m_sda = 1'b0;
	logic slow = 1'b0;
	logic ackd = 1'b0;
	logic [31:0] rdata_o;
	logic scl_o, scl_oe_o, sda_o, sda_oe_o, pins_en_o, p_scl_oe, p_sda_oe;
	logic [7:0] last;
	int n_errors = 0;
	int compares = 0;
	int cyc = 0;
	// Both lines are open drain with a pull-up.
	wire scl_w = !(scl_oe_o | p_scl_oe | m_scl);
	wire sda_w = !(sda_oe_o | p_sda_oe | m_sda);
	initial begin
		forever #20 mclk_i = ~mclk_i;
	end
	icsb_ctrl i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .idle_i(idle_i), .scl_i(scl_w),
		.sda_i(sda_w), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .pins_en_o(pins_en_o));
	icsb_slave_model i_peer (.scl_i(scl_w), .sda_i(sda_w), .slow_i(slow),
		.scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe), .last_o(last));
	always @(posedge scl_w) ackd = sda_w;
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			conclude();
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd
	task automatic rbit(input logic [7:0] a, input int b, input logic e, input string nm);
		logic [31:0] d;
		rd(a, d);
		chk(nm, {31'h0, e}, {31'h0, d[b]});
	endtask : rbit
	task automatic wclr(input logic [7:0] a, input int b);
		logic [31:0] d;
		d = '1;
		for (int i = 0; i < 3000 && d[b] !== 1'b0; i++) begin
			rd(a, d);
		end
		chk("busy bit", 32'h0, {31'h0, d[b]});
	endtask : wclr
	task automatic bb(input logic [8:0] b, output logic a);
		for (int i = 8; i >= 0; i--) begin
			m_sda <= !b[i];
			#160;
			m_scl <= 1'b0;
			#160;
			a = sda_w;
			m_scl <= 1'b1;
		end
	endtask : bb
	function automatic logic [7:0] hdr10(input logic [9:0] a);
		return {5'h1E, a[9:8], 1'b0};
	endfunction : hdr10
	task automatic conclude();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : conclude
	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [7:0] rb;
		logic a;
		void'($urandom(73));
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rd(8'h00, d);
		chk("control", 32'h1000, d);
		rd(8'h10, d);
		chk("status", 32'h0, d);
		wr(8'h04, 32'h1000);
		rbit(8'h00, 12, 1'b1, "release kept");
		wr(8'h08, 32'h0040);
		wr(8'h04, 32'h1000);
		rbit(8'h00, 12, 1'b0, "release held");
		wr(8'h08, 32'h1000);
		wr(8'h04, 32'h0040);
		wr(8'h30, 32'hFFFF);
		rd(8'h30, d);
		chk("unmapped", 32'h0, d);
		rd(8'h0C, d);
		chk("alias read", 32'h0, d);
		$display("test registers done");
		wr(8'h08, 32'hA000);
		wr(8'h08, 32'h0001);
		wclr(8'h00, 0);
		wr(8'h50, 32'h0054);
		rbit(8'h10, 0, 1'b1, "tx full");
		wr(8'h50, 32'h0011);
		rbit(8'h10, 7, 1'b1, "write collision");
		wr(8'h14, 32'h0080);
		rbit(8'h10, 7, 1'b0, "write collision");
		wclr(8'h10, 14);
		rd(8'h10, d);
		chk("ack and tx full", 32'h0, 32'({d[15], d[0]}));
		rb = 8'($urandom);
		slow <= 1'b1;
		wr(8'h50, {24'h0, rb});
		repeat (300) @(posedge mclk_i);
		idle_i <= 1'b1;
		repeat (40) @(posedge mclk_i);
		idle_i <= 1'b0;
		wclr(8'h10, 14);
		slow <= 1'b0;
		chk("peer byte", {24'h0, rb}, {24'h0, last});
		$display("test master write done");
		wr(8'h08, 32'h0002);
		wclr(8'h00, 1);
		wr(8'h50, 32'h0057);
		wclr(8'h10, 14);
		rbit(8'h10, 15, 1'b1, "nack seen");
		wr(8'h08, 32'h0002);
		wclr(8'h00, 1);
		wr(8'h50, 32'h0055);
		wclr(8'h10, 14);
		wr(8'h08, 32'h0008);
		wclr(8'h00, 3);
		rbit(8'h10, 1, 1'b1, "rx full");
		rd(8'h60, d);
		chk("rx byte", 32'h00A5, d);
		rbit(8'h10, 1, 1'b0, "rx full");
		wr(8'h08, 32'h0020);
		wr(8'h08, 32'h0010);
		wclr(8'h00, 4);
		chk("ack bit", 32'h1, {31'h0, ackd});
		wr(8'h08, 32'h0004);
		wclr(8'h00, 2);
		chk("lines free", 32'h0, {30'h0, scl_oe_o, sda_oe_o});
		chk("pin levels", 32'h3, {30'h0, scl_o, sda_o});
		$display("test master read done");
		wr(8'h08, 32'h0801);
		wclr(8'h00, 0);
		wr(8'h50, 32'h000E);
		repeat (10) @(posedge mclk_i);
		rd(8'h10, d);
		chk("reserved", 32'h8000, d & 32'hC001);
		wr(8'h04, 32'h0800);
		wr(8'h08, 32'h0004);
		wclr(8'h00, 2);
		m_sda <= 1'b1;
		wr(8'h08, 32'h0001);
		repeat (10) @(posedge mclk_i);
		m_sda <= 1'b0;
		rbit(8'h10, 10, 1'b1, "bus collision");
		wr(8'h14, 32'h0400);
		rbit(8'h10, 10, 1'b1, "bus collision");
		wr(8'h0C, 32'h8000);
		wr(8'h0C, 32'h8000);
		rbit(8'h10, 10, 1'b0, "bus collision");
		$display("test collision done");
		wr(8'h08, 32'h0080);
		#7;
		m_sda <= 1'b1;
		#160;
		m_scl <= 1'b1;
		bb(9'h001, a);
		chk("call ack", 32'h0, {31'h0, a});
		rd(8'h10, d);
		chk("call flags", 32'h0200, d & 32'h0220);
		m_sda <= 1'b1;
		#160;
		m_scl <= 1'b0;
		#160;
		m_sda <= 1'b0;
		#400;
		rd(8'h10, d);
		chk("call stop", 32'h0010, d & 32'h0210);
		$display("test general call done");
		wr(8'h20, 32'h02B5);
		wr(8'h08, 32'h0400);
		rb = 8'($urandom);
		#7;
		m_sda <= 1'b1;
		#160;
		m_scl <= 1'b1;
		bb({hdr10(10'h2B5), 1'b1}, a);
		chk("header ack", 32'h0, {31'h0, a});
		bb(9'h16B, a);
		chk("low byte ack", 32'h0, {31'h0, a});
		bb({rb, 1'b1}, a);
		chk("data ack", 32'h0, {31'h0, a});
		bb(9'h187, a);
		chk("overflow nack", 32'h1, {31'h0, a});
		rd(8'h10, d);
		chk("ten-bit flags", 32'h0162, d & 32'h0162);
		rd(8'h60, d);
		chk("kept byte", {24'h0, rb}, d);
		wr(8'h14, 32'h0040);
		#7;
		m_sda <= 1'b1;
		#160;
		m_scl <= 1'b0;
		#160;
		m_sda <= 1'b0;
		#400;
		rd(8'h10, d);
		chk("ten-bit stop", 32'h0010, d & 32'h0152);
		$display("test ten-bit slave done");
		conclude();
	end
endmodule : i2c_control_status_bank_tb_top
